// >>> design/mfp_consts.svh
// constants for the multi-function pin configuration block
`ifndef MFP_CONSTS_SVH
`define MFP_CONSTS_SVH
`define MFP_OFS_DATA_CFG 8'h3c
`define MFP_OFS_TX_CFG 8'h3d
`define MFP_OFS_RX_CFG 8'h3e
`define MFP_OFS_POL_MAP 8'h36
`define MFP_OFS_KILL_MAP 8'h5d
`define MFP_OFS_MODE 8'h40
`define MFP_OFS_STATUS 8'h41
`define MFP_CFG_RESET 8'h00
`define MFP_MAP_RESET 8'h00
`define MFP_MODE_RESET 8'h00
`define MFP_FN_LSB 0
`define MFP_FN_MSB 3
`define MFP_ANALOG_BIT 6
`define MFP_PULLUP_BIT 7
`define MFP_KILL_DATA_BIT 1
`define MFP_KILL_TX_BIT 2
`define MFP_KILL_RX_BIT 3
`define MFP_MODE_ANALOG_BIT 0
`define MFP_MODE_ENCODER_BIT 1
`endif

// >>> design/mfp_pkg.sv
// types for the multi-function pin configuration block
package mfp_pkg;
    typedef enum logic [3:0] {
        MFP_FN_DEFAULT = 4'h0,
        MFP_FN_USER_IO = 4'h1,
        MFP_FN_USER_IN = 4'h2,
        MFP_FN_SERIAL = 4'h4,
        MFP_FN_ENCODER = 4'h6,
        MFP_FN_KILL = 4'h7
    } mfp_fn_e;
    typedef struct packed {
        mfp_fn_e func;
        logic analog_en;
        logic pullup_en;
        logic active_high;
        logic kill_sw;
    } mfp_pin_s;
endpackage

// >>> design/mfp_pin_config.sv
// per-pin function selection for the data, transmit and receive pins
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "mfp_consts.svh"
module mfp_pin_config
    import mfp_pkg::*;
(
    input wire logic mclk, // 100 MHz clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic [7:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    output mfp_pin_s data_pin, // resolved data pin setup
    output mfp_pin_s tx_pin, // resolved transmit pin setup
    output mfp_pin_s rx_pin // resolved receive pin setup
);
    logic [7:0] data_cfg_reg;
    logic [7:0] tx_cfg_reg;
    logic [7:0] rx_cfg_reg;
    logic [7:0] pol_map_reg;
    logic [7:0] kill_map_reg;
    logic [7:0] mode_reg;
    mfp_pin_s data_next;
    mfp_pin_s tx_next;
    mfp_pin_s rx_next;
    logic [7:0] rdata_next;
    logic analog_mode;
    logic encoder_mode;

    // config bytes, stored as written; reserved bits kept so software reads back its value
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            data_cfg_reg <= `MFP_CFG_RESET;
            tx_cfg_reg <= `MFP_CFG_RESET;
            rx_cfg_reg <= `MFP_CFG_RESET;
        end
        else if (wr)
        begin
            if (addr == `MFP_OFS_DATA_CFG)
                data_cfg_reg <= wdata;
            else if (addr == `MFP_OFS_TX_CFG)
                tx_cfg_reg <= wdata;
            else if (addr == `MFP_OFS_RX_CFG)
                rx_cfg_reg <= wdata;
        end
    end

    // polarity and kill maps live apart from the config bytes
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            pol_map_reg <= `MFP_MAP_RESET;
            kill_map_reg <= `MFP_MAP_RESET;
        end
        else if (wr)
        begin
            if (addr == `MFP_OFS_POL_MAP)
                pol_map_reg <= wdata;
            else if (addr == `MFP_OFS_KILL_MAP)
                kill_map_reg <= wdata;
        end
    end

    // control mode: bit 0 analog family, bit 1 encoder family
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            mode_reg <= `MFP_MODE_RESET;
        else if (wr && addr == `MFP_OFS_MODE)
            mode_reg <= wdata;
    end

    assign analog_mode = mode_reg[`MFP_MODE_ANALOG_BIT];
    assign encoder_mode = mode_reg[`MFP_MODE_ENCODER_BIT];

    // data pin resolve; unknown codes fall back to default so the pin never floats in role
    always_comb
    begin
        data_next = '0;
        data_next.active_high = pol_map_reg[`MFP_KILL_DATA_BIT];
        data_next.kill_sw = kill_map_reg[`MFP_KILL_DATA_BIT];
        case (data_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB])
            4'h1, 4'h2, 4'h4, 4'h7:
            begin
                data_next.func = mfp_fn_e'(data_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB]);
                data_next.analog_en = data_cfg_reg[`MFP_ANALOG_BIT];
                data_next.pullup_en = data_cfg_reg[`MFP_PULLUP_BIT];
            end
            default:
            begin
                if (analog_mode)
                begin
                    data_next.func = MFP_FN_USER_IN;
                    data_next.analog_en = 1'b1;
                end
                else
                begin
                    data_next.func = MFP_FN_SERIAL;
                    data_next.pullup_en = 1'b1;
                end
            end
        endcase
    end

    // transmit pin resolve; pull-up fixed on whatever bit seven says
    always_comb
    begin
        tx_next = '0;
        tx_next.pullup_en = 1'b1;
        tx_next.active_high = pol_map_reg[`MFP_KILL_TX_BIT];
        tx_next.kill_sw = kill_map_reg[`MFP_KILL_TX_BIT];
        case (tx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB])
            4'h1, 4'h2, 4'h4, 4'h6, 4'h7:
            begin
                tx_next.func = mfp_fn_e'(tx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB]);
                tx_next.analog_en = tx_cfg_reg[`MFP_ANALOG_BIT];
            end
            default:
                tx_next.func = encoder_mode ? MFP_FN_ENCODER : MFP_FN_SERIAL;
        endcase
    end

    // receive pin resolve; same shape as transmit
    always_comb
    begin
        rx_next = '0;
        rx_next.pullup_en = 1'b1;
        rx_next.active_high = pol_map_reg[`MFP_KILL_RX_BIT];
        rx_next.kill_sw = kill_map_reg[`MFP_KILL_RX_BIT];
        case (rx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB])
            4'h1, 4'h2, 4'h4, 4'h6, 4'h7:
            begin
                rx_next.func = mfp_fn_e'(rx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB]);
                rx_next.analog_en = rx_cfg_reg[`MFP_ANALOG_BIT];
            end
            default:
                rx_next.func = encoder_mode ? MFP_FN_ENCODER : MFP_FN_SERIAL;
        endcase
    end

    // resolved setups registered so outputs come from flip-flops
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            data_pin <= '0;
            tx_pin <= '0;
            rx_pin <= '0;
        end
        else
        begin
            data_pin <= data_next;
            tx_pin <= tx_next;
            rx_pin <= rx_next;
        end
    end

    // read decode; status returns data pin function and analog/pull-up state
    always_comb
    begin
        if (addr == `MFP_OFS_DATA_CFG)
            rdata_next = data_cfg_reg;
        else if (addr == `MFP_OFS_TX_CFG)
            rdata_next = tx_cfg_reg;
        else if (addr == `MFP_OFS_RX_CFG)
            rdata_next = rx_cfg_reg;
        else if (addr == `MFP_OFS_POL_MAP)
            rdata_next = pol_map_reg;
        else if (addr == `MFP_OFS_KILL_MAP)
            rdata_next = kill_map_reg;
        else if (addr == `MFP_OFS_MODE)
            rdata_next = mode_reg;
        else if (addr == `MFP_OFS_STATUS)
            rdata_next = {data_pin.pullup_en, data_pin.analog_en, 2'h0, data_pin.func};
        else
            rdata_next = 8'h00; // unmapped reads zero
    end

    // read data valid only the cycle after rd
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            rdata <= 8'h00;
        else if (rd)
            rdata <= rdata_next;
        else
            rdata <= 8'h00;
    end

    // every antecedent needs rstn sampled high: on the release edge the pin flops still hold zero
    sequence s_data_listed;
        rstn && data_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB] inside {4'h1, 4'h2, 4'h4, 4'h7};
    endsequence

    sequence s_data_default;
        rstn && data_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB] == 4'h0 && !analog_mode;
    endsequence

    sequence s_data_analog_default;
        rstn && data_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB] == 4'h0 && analog_mode;
    endsequence

    sequence s_data_unlisted;
        rstn && !(data_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB] inside {4'h1, 4'h2, 4'h4, 4'h7});
    endsequence

    sequence s_tx_listed;
        rstn && tx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h7};
    endsequence

    sequence s_tx_unlisted;
        rstn && !(tx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h7});
    endsequence

    sequence s_rx_listed;
        rstn && rx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h7};
    endsequence

    sequence s_rx_unlisted;
        rstn && !(rx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB] inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h7});
    endsequence

    sequence s_map_write;
        rstn && wr && (addr == `MFP_OFS_POL_MAP || addr == `MFP_OFS_KILL_MAP);
    endsequence

    // data pin checks
    a_data_code_pass: assert property (@(posedge mclk) disable iff (!rstn)
        s_data_listed |=> data_pin.func == $past(data_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB]))
        else $error("data pin function does not follow its code");
    a_data_default_i2c: assert property (@(posedge mclk) disable iff (!rstn)
        s_data_default |=> data_pin.func == MFP_FN_SERIAL && data_pin.pullup_en)
        else $error("data pin default not i2c with pull-up");
    a_data_analog_default: assert property (@(posedge mclk) disable iff (!rstn)
        s_data_analog_default |=> data_pin.func == MFP_FN_USER_IN
        && data_pin.analog_en && !data_pin.pullup_en)
        else $error("data pin analog default wrong");
    a_data_pullup_bit: assert property (@(posedge mclk) disable iff (!rstn)
        s_data_listed |=> data_pin.pullup_en == $past(data_cfg_reg[`MFP_PULLUP_BIT]))
        else $error("data pin pull-up does not follow bit seven");
    a_data_analog_bit: assert property (@(posedge mclk) disable iff (!rstn)
        s_data_listed |=> data_pin.analog_en == $past(data_cfg_reg[`MFP_ANALOG_BIT]))
        else $error("data pin analog enable does not follow bit six");
    a_data_unlisted_code: assert property (@(posedge mclk) disable iff (!rstn)
        s_data_unlisted |=> data_pin.func
        == ($past(analog_mode) ? MFP_FN_USER_IN : MFP_FN_SERIAL))
        else $error("data pin took an unlisted role");
    a_data_default_plain: assert property (@(posedge mclk) disable iff (!rstn)
        s_data_default |=> !data_pin.analog_en)
        else $error("data pin default kept a byte option");

    // transmit pin checks
    a_tx_pullup_fixed: assert property (@(posedge mclk) disable iff (!rstn)
        rstn |=> tx_pin.pullup_en && rx_pin.pullup_en)
        else $error("transmit or receive pull-up dropped");
    a_tx_code_pass: assert property (@(posedge mclk) disable iff (!rstn)
        s_tx_listed |=> tx_pin.func == $past(tx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB])
        && tx_pin.analog_en == $past(tx_cfg_reg[`MFP_ANALOG_BIT]))
        else $error("transmit pin does not follow its code");
    a_tx_encoder_default: assert property (@(posedge mclk) disable iff (!rstn)
        s_tx_unlisted |=> tx_pin.func
        == ($past(encoder_mode) ? MFP_FN_ENCODER : MFP_FN_SERIAL))
        else $error("transmit default role wrong");
    a_tx_default_plain: assert property (@(posedge mclk) disable iff (!rstn)
        s_tx_unlisted |=> !tx_pin.analog_en)
        else $error("transmit default kept a byte option");

    // receive pin checks
    a_rx_code_pass: assert property (@(posedge mclk) disable iff (!rstn)
        s_rx_listed |=> rx_pin.func == $past(rx_cfg_reg[`MFP_FN_MSB:`MFP_FN_LSB]))
        else $error("receive pin does not follow its code");
    a_rx_encoder_default: assert property (@(posedge mclk) disable iff (!rstn)
        s_rx_unlisted |=> rx_pin.func
        == ($past(encoder_mode) ? MFP_FN_ENCODER : MFP_FN_SERIAL) && !rx_pin.analog_en)
        else $error("receive default role wrong");
    a_rx_unlisted_code: assert property (@(posedge mclk) disable iff (!rstn)
        s_rx_unlisted |=> rx_pin.func inside {MFP_FN_ENCODER, MFP_FN_SERIAL})
        else $error("receive pin took an unlisted role");
    a_rx_analog_bit: assert property (@(posedge mclk) disable iff (!rstn)
        s_rx_listed |=> rx_pin.analog_en == $past(rx_cfg_reg[`MFP_ANALOG_BIT]))
        else $error("receive analog enable wrong");

    // map checks
    a_kill_map_bits: assert property (@(posedge mclk) disable iff (!rstn)
        rstn |=> tx_pin.kill_sw == $past(kill_map_reg[`MFP_KILL_TX_BIT])
        && data_pin.kill_sw == $past(kill_map_reg[`MFP_KILL_DATA_BIT])
        && rx_pin.kill_sw == $past(kill_map_reg[`MFP_KILL_RX_BIT]))
        else $error("kill map bit misplaced");
    a_polarity_map: assert property (@(posedge mclk) disable iff (!rstn)
        rstn |=> rx_pin.active_high == $past(pol_map_reg[`MFP_KILL_RX_BIT])
        && tx_pin.active_high == $past(pol_map_reg[`MFP_KILL_TX_BIT])
        && data_pin.active_high == $past(pol_map_reg[`MFP_KILL_DATA_BIT]))
        else $error("pin polarity wrong");
    a_maps_apart: assert property (@(posedge mclk) disable iff (!rstn)
        s_map_write |=> data_cfg_reg == $past(data_cfg_reg)
        && tx_cfg_reg == $past(tx_cfg_reg) && rx_cfg_reg == $past(rx_cfg_reg))
        else $error("map write disturbed a config byte");
endmodule

// >>> test/mfp_wiring.sv
// external wiring model: idle level seen on each multi-function pin
`timescale 1ns/100ps
module mfp_wiring
    import mfp_pkg::*;
(
    input wire logic mclk, // bench clock
    input wire mfp_pin_s data_pin, // data pin setup
    input wire mfp_pin_s tx_pin, // transmit pin setup
    input wire mfp_pin_s rx_pin, // receive pin setup
    output logic [2:0] line // idle level {rx, tx, data}
);
    logic toggle = 1'b0;
    // a floating line wanders every cycle, so no level is taken on trust
    always_ff @(posedge mclk)
        toggle <= ~toggle;
    // a released line rests high only where its pull-up is on
    assign line[0] = data_pin.pullup_en ? 1'b1 : toggle;
    assign line[1] = tx_pin.pullup_en ? 1'b1 : toggle;
    assign line[2] = rx_pin.pullup_en ? 1'b1 : toggle;
endmodule

// >>> test/tb_top.sv
// self-checking bench for the multi-function pin configuration block
`timescale 1ns/100ps
module tb_top
    import mfp_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    mfp_pin_s data_pin, tx_pin, rx_pin;
    logic [2:0] line;
    int n_errors = 0;
    int compares = 0;
    logic [3:0] dc [4] = '{4'h1, 4'h2, 4'h4, 4'h7};
    logic [3:0] tc [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h7};
    logic [3:0] uc [3] = '{4'h3, 4'h5, 4'h0};

    mfp_pin_config mfp_pin_config_i (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .data_pin(data_pin), .tx_pin(tx_pin), .rx_pin(rx_pin));
    mfp_wiring mfp_wiring_i (.mclk(mclk), .data_pin(data_pin), .tx_pin(tx_pin),
        .rx_pin(rx_pin), .line(line));

    // 100 MHz clock
    initial forever #5 mclk = ~mclk;

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one write cycle, then wait until the pin outputs have caught up
    task setp(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge mclk);
        #1;
        chk(rdata, 8'h00);
    endtask

    task pins(input logic [7:0] d, input logic [7:0] t, input logic [7:0] r);
        chk(data_pin, d);
        chk(tx_pin, t);
        chk(rx_pin, r);
    endtask

    // all config bytes written below keep bits 4-5 at zero
    initial
    begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        pins(8'h44, 8'h44, 8'h44);
        chk({5'h0, line}, 8'h07);
        for (int i = 0; i < 3; i++)
            rd_chk(8'(8'h3c + i), 8'h00);
        foreach (dc[i])
        begin
            setp(8'h3c, {4'hc, dc[i]});
            pins({dc[i], 4'hc}, 8'h44, 8'h44);
            setp(8'h3c, {4'h4, dc[i]});
            pins({dc[i], 4'h8}, 8'h44, 8'h44);
        end
        rd_chk(8'h3c, 8'h47);
        foreach (uc[i])
        begin
            setp(8'h3c, {4'hc, uc[i]});
            pins(8'h44, 8'h44, 8'h44);
        end
        foreach (tc[i])
        begin
            setp(8'h3d, {4'h4, tc[i]});
            setp(8'h3e, {4'h0, tc[i]});
            pins(8'h44, {tc[i], 4'hc}, {tc[i], 4'h4});
        end
        setp(8'h3d, 8'hc5);
        setp(8'h3e, 8'hc3);
        pins(8'h44, 8'h44, 8'h44);
        rd_chk(8'h3d, 8'hc5);
        rd_chk(8'h3e, 8'hc3);
        setp(8'h40, 8'h01);
        pins(8'h28, 8'h44, 8'h44);
        rd_chk(8'h41, 8'h42);
        setp(8'h40, 8'h02);
        pins(8'h44, 8'h64, 8'h64);
        rd_chk(8'h40, 8'h02);
        rd_chk(8'h41, 8'h84);
        setp(8'h40, 8'h00);
        setp(8'h36, 8'h02);
        setp(8'h5d, 8'h04);
        setp(8'h3c, 8'h07);
        setp(8'h3d, 8'h07);
        setp(8'h3e, 8'h07);
        pins(8'h72, 8'h75, 8'h74);
        setp(8'h36, 8'h0c);
        setp(8'h5d, 8'h0a);
        pins(8'h71, 8'h76, 8'h77);
        chk({6'h0, line[2:1]}, 8'h03);
        rd_chk(8'h36, 8'h0c);
        rd_chk(8'h5d, 8'h0a);
        setp(8'h00, 8'hff);
        rd_chk(8'h00, 8'h00);
        setp(8'h41, 8'hff);
        rd_chk(8'h41, 8'h07);
        // a second reset mid-run must clear every byte and bring back the default roles
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        pins(8'h00, 8'h00, 8'h00);
        @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        pins(8'h44, 8'h44, 8'h44);
        rd_chk(8'h3d, 8'h00);
        rd_chk(8'h5d, 8'h00);
        print_verdict;
    end

    // hang guard, well past the two hundred or so cycles the tests need
    initial
    begin
        #100000;
        n_errors++;
        print_verdict;
    end
endmodule
